// *** common/psr_evt_if.sv ***
// interface between the bank and its event catcher
`timescale 1ns/1ns
interface psr_evt_if;
	import psr_pkg::*;
	psr_event_type level_in;  // raw condition levels
	logic          rd_clear;  // status register read taken this cycle
	logic [1:0]    sticky;    // latched jabber and far-end fault
	psr_event_type rise;      // condition went high this cycle
	psr_event_type change;    // condition changed this cycle

	modport catcher (
		input  level_in,
		input  rd_clear,
		output sticky,
		output rise,
		output change
	);
	modport user (
		output level_in,
		output rd_clear,
		input  sticky,
		input  rise,
		input  change
	);
endinterface

// *** common/psr_pkg.sv ***
// types shared by the phy status bank files
package psr_pkg;
	typedef logic [31:0] psr_word_type;   // bus data word
	typedef logic [15:0] psr_half_type;   // management register width
	typedef logic [3:0]  psr_event_type;  // one bit per event source
	typedef logic [5:0]  psr_index_type;  // register index from the address

	// decoded register selection
	typedef enum logic [2:0] {
		PSR_SEL_NONE,
		PSR_SEL_STATUS,
		PSR_SEL_ID_HIGH,
		PSR_SEL_ID_LOW,
		PSR_SEL_INT_STAT,
		PSR_SEL_INT_MASK
	} psr_sel_type;
endpackage

// *** common/psr_regs.svh ***
// register indices, fields, reset values and timing of the phy status bank
`ifndef PSR_REGS_SVH
`define PSR_REGS_SVH

// ********************************************************************
// register indices (byte address is four times the index)
// ********************************************************************
`define PSR_IDX_STATUS     6'h01
`define PSR_IDX_ID_HIGH    6'h02
`define PSR_IDX_ID_LOW     6'h03
`define PSR_IDX_INT_STAT   6'h10
`define PSR_IDX_INT_MASK   6'h11

// ********************************************************************
// status word fields
// ********************************************************************
`define PSR_ST_CAP_FAST_FD 14
`define PSR_ST_CAP_FAST_HD 13
`define PSR_ST_CAP_SLOW_FD 12
`define PSR_ST_CAP_SLOW_HD 11
`define PSR_ST_NO_PREAMBLE 6
`define PSR_ST_AUTONEG_DONE 5
`define PSR_ST_FAR_FAULT   4
`define PSR_ST_AUTONEG_CAP 3
`define PSR_ST_LINK        2
`define PSR_ST_JABBER      1
`define PSR_ST_EXT_REGS    0

// ********************************************************************
// event bits, shared by level inputs and interrupt status/mask
// ********************************************************************
`define PSR_EV_JABBER      0
`define PSR_EV_FAULT       1
`define PSR_EV_LINK        2
`define PSR_EV_AUTONEG     3

// ********************************************************************
// reset values
// ********************************************************************
`define PSR_STATUS_RESET   16'h7849
`define PSR_INT_RESET      4'h0
`define PSR_WORD_ZERO      32'h00000000

// ********************************************************************
// timing: zero wait states, answer one edge after the address phase
// ********************************************************************
`define PSR_WAIT_STATES    0

`endif

// *** logic/psr_event_catch.sv ***
// edge detection of the condition inputs and clear-on-read latching of jabber and fault
`timescale 1ns/1ns
module psr_event_catch (
	input wire logic hclk,
	input wire logic hresetn,
	psr_evt_if.catcher ev
);
	import psr_pkg::*;

	psr_event_type prev;  // last cycle's condition levels

	// ****************************************************************
	// per-source edge detect, sticky latch for sources 0 and 1 only
	// ****************************************************************
	genvar i;
	generate
		for (i = 0; i < 4; i++) begin : g_src
			// previous level, reset low so a high input at release is an edge
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					prev[i] <= 1'b0;
				end else begin
					prev[i] <= ev.level_in[i];
				end
			end
			assign ev.rise[i]   = ev.level_in[i] & ~prev[i];
			assign ev.change[i] = ev.level_in[i] ^ prev[i];
			if (i < 2) begin : g_sticky
				// a live condition beats the read clear, so no event is lost
				always_ff @(posedge hclk or negedge hresetn) begin
					if (!hresetn) begin
						ev.sticky[i] <= 1'b0;
					end else begin
						ev.sticky[i] <= (ev.sticky[i] & ~ev.rd_clear) |
							ev.level_in[i];
					end
				end
				// a latched flag survives until a read while the source is quiet
				chk_sticky_keep: assert property (
					@(posedge hclk) disable iff (!hresetn)
					ev.sticky[i] && !ev.rd_clear |=> ev.sticky[i])
					else $error("sticky flag dropped without a read");
			end
		end
	endgenerate
endmodule

// *** logic/psr_top.sv ***
// phy status and identifier register bank with an ahb-lite slave port
//
// Overview of operation
// - status bits 14,13 read one: fast duplexes
// - status bits 12,11 read one: slow duplexes
// - status bit 6 one: preamble-less frames accepted
// - status bit 5 shows autonegotiation done, no reset value
// - status bit 3 one: autonegotiation capable
// - status bit 2 follows link directly, no reset value
// - jabber bit 1 sticky until status read
// - status bit 0 one: extended registers exist
// - reserved status bits 15, 10:7 read zero
// - two read-only identifier registers, indices 2,3
// - maker code spans high register, low bits 15:10
// - revision in identifier low bits 3:0
`timescale 1ns/1ns
`include "psr_regs.svh"
module psr_top #(
	parameter logic [15:0] ID_HIGH    = 16'h5A3C, // arbitrary value
	parameter logic [5:0]  OUI_LOW    = 6'h2B,    // arbitrary value
	parameter logic [5:0]  MODEL      = 6'h11,    // arbitrary value
	parameter logic [3:0]  REVISION   = 4'h2      // arbitrary value
) (
	input  wire logic                  hclk,
	input  wire logic                  hresetn,
	input  wire logic                  hsel,
	input  wire psr_pkg::psr_word_type haddr,
	input  wire logic [1:0]            htrans,
	input  wire logic                  hwrite,
	input  wire logic [2:0]            hsize,
	input  wire psr_pkg::psr_word_type hwdata,
	input  wire logic                  hready,
	output      psr_pkg::psr_word_type hrdata,
	output      logic                  hreadyout,
	output      logic                  hresp,
	input  wire logic                  link_up,
	input  wire logic                  autoneg_complete,
	input  wire logic                  jabber_detect,
	input  wire logic                  far_end_fault_detect,
	output      logic                  irq
);
	import psr_pkg::*;

	// ****************************************************************
	// declarations
	// ****************************************************************
	psr_evt_if     ev();            // link to the event catcher
	logic          addr_take;       // address phase accepted this edge
	psr_index_type addr_index;      // word index from the address
	psr_sel_type   addr_sel;        // register picked by the address
	psr_sel_type   dp_sel;          // register of the pending data phase
	logic          dp_write;        // pending data phase is a write
	psr_half_type  status_word;     // live status register contents
	psr_half_type  id_low_word;     // second identifier register
	psr_word_type  read_value;      // word returned for the address phase
	psr_event_type int_status;      // sticky interrupt events
	psr_event_type int_mask;        // interrupt enables
	psr_event_type events;          // this cycle's interrupt events
	psr_event_type stat_clear;      // write-one-to-clear request
	psr_event_type next_int_status; // interrupt status after this edge
	logic          irq_cause;       // unmasked event pending

	// ****************************************************************
	// event catcher
	// ****************************************************************
	// condition inputs are taken as already synchronous to hclk
	assign ev.level_in[`PSR_EV_JABBER]  = jabber_detect;
	assign ev.level_in[`PSR_EV_FAULT]   = far_end_fault_detect;
	assign ev.level_in[`PSR_EV_LINK]    = link_up;
	assign ev.level_in[`PSR_EV_AUTONEG] = autoneg_complete;

	psr_event_catch u_catch (
		.hclk    (hclk),
		.hresetn (hresetn),
		.ev      (ev)
	);

	// ****************************************************************
	// address phase decode
	// ****************************************************************
	// a transfer counts only on nonseq/seq with the bus ready
	assign addr_take  = hsel & htrans[1] & hready;
	assign addr_index = haddr[7:2];

	// register select; addresses above the map fall to none
	always_comb begin
		addr_sel = PSR_SEL_NONE;
		if (haddr[31:8] == 24'h000000) begin
			unique case (addr_index)
				`PSR_IDX_STATUS:   addr_sel = PSR_SEL_STATUS;
				`PSR_IDX_ID_HIGH:  addr_sel = PSR_SEL_ID_HIGH;
				`PSR_IDX_ID_LOW:   addr_sel = PSR_SEL_ID_LOW;
				`PSR_IDX_INT_STAT: addr_sel = PSR_SEL_INT_STAT;
				`PSR_IDX_INT_MASK: addr_sel = PSR_SEL_INT_MASK;
				// unmapped index, read as zero and write ignored
				default:           addr_sel = PSR_SEL_NONE;
			endcase
		end
	end

	// ****************************************************************
	// status and identifier contents
	// ****************************************************************
	// fixed capability bits are tied high and reserved bits stay zero;
	// the four live bits come from the inputs and the latches
	always_comb begin
		status_word = 16'h0000;
		status_word[`PSR_ST_CAP_FAST_FD] = 1'b1;
		status_word[`PSR_ST_CAP_FAST_HD] = 1'b1;
		status_word[`PSR_ST_CAP_SLOW_FD] = 1'b1;
		status_word[`PSR_ST_CAP_SLOW_HD] = 1'b1;
		status_word[`PSR_ST_NO_PREAMBLE] = 1'b1;
		status_word[`PSR_ST_AUTONEG_DONE] = autoneg_complete;
		status_word[`PSR_ST_FAR_FAULT] = ev.sticky[1];
		status_word[`PSR_ST_AUTONEG_CAP] = 1'b1;
		status_word[`PSR_ST_LINK] = link_up;
		status_word[`PSR_ST_JABBER] = ev.sticky[0];
		status_word[`PSR_ST_EXT_REGS] = 1'b1;
	end

	// maker low bits, model, revision packed into the second word
	assign id_low_word = {OUI_LOW, MODEL, REVISION};

	// read multiplexer; upper half of every word reads zero
	always_comb begin
		read_value = `PSR_WORD_ZERO;
		unique case (addr_sel)
			PSR_SEL_STATUS:   read_value = {16'h0000, status_word};
			PSR_SEL_ID_HIGH:  read_value = {16'h0000, ID_HIGH};
			PSR_SEL_ID_LOW:   read_value = {16'h0000, id_low_word};
			PSR_SEL_INT_STAT: read_value = {28'h0000000, int_status};
			PSR_SEL_INT_MASK: read_value = {28'h0000000, int_mask};
			PSR_SEL_NONE:     read_value = `PSR_WORD_ZERO;
			// illegal select code, treat like an unmapped address
			default:          read_value = `PSR_WORD_ZERO;
		endcase
	end

	// a status read taken now clears the latched flags at this edge
	assign ev.rd_clear = addr_take & ~hwrite &
		(addr_sel == PSR_SEL_STATUS);

	// ****************************************************************
	// bus slave: data phase tracking
	// ****************************************************************
	// remembers what the accepted address phase asked for
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_write <= 1'b0;
			dp_sel   <= PSR_SEL_NONE;
		end else if (addr_take) begin
			dp_write <= hwrite;
			dp_sel   <= addr_sel;
		end else begin
			dp_write <= 1'b0;
			dp_sel   <= PSR_SEL_NONE;
		end
	end

	// read data is captured at the address edge so hrdata is a flop;
	// the trade is that the value is the one sampled at that edge
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= `PSR_WORD_ZERO;
		end else if (addr_take && !hwrite) begin
			hrdata <= read_value;
		end
	end

	// never inserts wait states and never errors
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// ****************************************************************
	// interrupt status, mask and output
	// ****************************************************************
	// events: new jabber, new fault, any link change, negotiation end
	assign events[`PSR_EV_JABBER]  = ev.rise[`PSR_EV_JABBER];
	assign events[`PSR_EV_FAULT]   = ev.rise[`PSR_EV_FAULT];
	assign events[`PSR_EV_LINK]    = ev.change[`PSR_EV_LINK];
	assign events[`PSR_EV_AUTONEG] = ev.rise[`PSR_EV_AUTONEG];

	// write data arrives in the data phase, hence dp_* qualifiers
	assign stat_clear = (dp_write && dp_sel == PSR_SEL_INT_STAT) ?
		hwdata[3:0] : `PSR_INT_RESET;

	// set wins over clear so an event in the clear cycle stays
	assign next_int_status = (int_status & ~stat_clear) | events;

	// sticky event bits
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			int_status <= `PSR_INT_RESET;
		end else begin
			int_status <= next_int_status;
		end
	end

	// mask register, fully writable
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			int_mask <= `PSR_INT_RESET;
		end else if (dp_write && dp_sel == PSR_SEL_INT_MASK) begin
			int_mask <= hwdata[3:0];
		end
	end

	// any unmasked pending event asks for service
	assign irq_cause = |(int_status & int_mask);

	// level output, one cycle behind the status so it stays a flop
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= irq_cause;
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	// accepted read of the status word
	sequence status_read_take;
		addr_take && !hwrite && (addr_sel == PSR_SEL_STATUS);
	endsequence

	// accepted read of either identifier word
	sequence id_high_read_take;
		addr_take && !hwrite && (addr_sel == PSR_SEL_ID_HIGH);
	endsequence

	sequence id_low_read_take;
		addr_take && !hwrite && (addr_sel == PSR_SEL_ID_LOW);
	endsequence

	chk_fast_caps: assert property (
		status_read_take |=> hrdata[14:13] == 2'b11)
		else $error("fast duplex capability bits not one");

	chk_slow_caps: assert property (
		status_read_take |=> hrdata[12:11] == 2'b11)
		else $error("slow duplex capability bits not one");

	chk_no_preamble: assert property (
		status_read_take |=> hrdata[6] && hrdata[3])
		else $error("preamble or autoneg capability bit not one");

	chk_autoneg_done: assert property (
		status_read_take |=> hrdata[5] == $past(autoneg_complete))
		else $error("autoneg done bit does not follow input");

	chk_autoneg_cap: assert property (
		status_read_take ##1 !addr_take |-> hrdata[3])
		else $error("autoneg capability bit lost");

	chk_link_bit: assert property (
		status_read_take |=> hrdata[2] == $past(link_up))
		else $error("link bit does not follow input");

	chk_jabber_set: assert property (
		jabber_detect |=> ev.sticky[0] [*1] ##0 status_word[1])
		else $error("jabber flag not latched");

	chk_jabber_clear: assert property (
		status_read_take ##0 !jabber_detect |=> !ev.sticky[0])
		else $error("jabber flag not cleared by status read");

	chk_ext_regs: assert property (
		status_read_take |=> hrdata[0])
		else $error("extended register bit not one");

	chk_status_rsvd: assert property (
		status_read_take |=> hrdata[31:15] == 17'h00000 &&
			hrdata[10:7] == 4'h0)
		else $error("reserved status bits not zero");

	chk_id_words: assert property (
		id_high_read_take |=> hrdata == {16'h0000, ID_HIGH})
		else $error("identifier high word wrong");

	chk_revision: assert property (
		id_low_read_take |=> hrdata[15:10] == OUI_LOW &&
			hrdata[3:0] == REVISION)
		else $error("identifier low word wrong");

	chk_fault_flow: assert property (
		far_end_fault_detect ##1 status_read_take ##0
			!far_end_fault_detect |=> !status_word[4])
		else $error("far-end fault flag flow broken");

	chk_irq_level: assert property (
		irq == $past(irq_cause))
		else $error("interrupt output does not track status");

	chk_set_wins: assert property (
		events[0] |=> int_status[0])
		else $error("interrupt event lost against clear");

	chk_zero_wait: assert property (
		addr_take |=> hreadyout && !hresp)
		else $error("slave stalled or errored");

	// ****************************************************************
	// register and interrupt bookkeeping checks
	// ****************************************************************
	// with every live bit low the word is exactly the reset pattern
	chk_status_pattern: assert property (
		!autoneg_complete && !link_up && ev.sticky == 2'b00 |->
			status_word == `PSR_STATUS_RESET)
		else $error("status word differs from its reset pattern");

	// read data stands until the next read is taken
	chk_rdata_hold: assert property (
		!(addr_take && !hwrite) |=> $stable(hrdata))
		else $error("read data changed without a read");

	// the mask moves only on a data phase aimed at it
	chk_mask_hold: assert property (
		!(dp_write && dp_sel == PSR_SEL_INT_MASK) |=> $stable(int_mask))
		else $error("interrupt mask changed without a write");

	// data phase of a write to the interrupt status
	sequence stat_write_take;
		dp_write && (dp_sel == PSR_SEL_INT_STAT);
	endsequence

	// a one written clears its bit unless an event sets it again
	chk_w1c_clear: assert property (
		stat_write_take ##0 events == 4'h0 |=>
			(int_status & $past(stat_clear)) == 4'h0)
		else $error("written one did not clear its status bit");

	// every event lands in the status at the next edge
	chk_events_land: assert property (
		events != 4'h0 |=> (int_status & $past(events)) == $past(events))
		else $error("interrupt event did not land");

endmodule

// *** verification/psr_mgmt_station.sv ***
// management station model: an ahb-lite master that reads and writes the bank
`timescale 1ns/1ns
module psr_mgmt_station (
	input  wire logic                  hclk,
	input  wire logic                  hready,
	input  wire psr_pkg::psr_word_type hrdata,
	output      logic                  hsel,
	output      psr_pkg::psr_word_type haddr,
	output      logic [1:0]            htrans,
	output      logic                  hwrite,
	output      logic [2:0]            hsize,
	output      psr_pkg::psr_word_type hwdata
);
	import psr_pkg::*;

	// ********************************************************************
	// idle bus at time zero
	// ********************************************************************
	initial begin
		hsel   = 1'b0;
		haddr  = 32'h00000000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize  = 3'h2;
		hwdata = 32'hA5A5A5A5;
	end

	// ********************************************************************
	// one single word transfer, address phase then data phase
	// ********************************************************************
	// no cycle count is assumed: each phase ends only on hready high
	task automatic bus_xfer(
		input  logic          wr,
		input  psr_index_type idx,
		input  psr_word_type  wdata,
		output psr_word_type  rdata
	);
		@(posedge hclk);
		hsel   <= 1'b1;
		haddr  <= {24'h000000, idx, 2'b00};
		htrans <= 2'b10;
		hwrite <= wr;
		hsize  <= 3'h2;
		@(posedge hclk);
		while (hready !== 1'b1) begin
			@(posedge hclk);
		end
		// released address lines show a changed pattern, not the old one
		hsel   <= 1'b0;
		htrans <= 2'b00;
		haddr  <= ~{24'h000000, idx, 2'b00};
		hwdata <= wdata;
		@(posedge hclk);
		while (hready !== 1'b1) begin
			@(posedge hclk);
		end
		rdata = hrdata;
		hwdata <= ~wdata;
	endtask
endmodule

// *** verification/tb_psr_top.sv ***
// self-checking testbench of the phy status and identifier bank
`timescale 1ns/1ns
`include "psr_regs.svh"
module tb_psr_top;
	import psr_pkg::*;

	// ********************************************************************
	// identity parameters and expected words
	// ********************************************************************
	localparam logic [15:0] ID_HI = 16'h4D21; // arbitrary value
	localparam logic [5:0]  OUI_L = 6'h15;    // arbitrary value
	localparam logic [5:0]  MDL   = 6'h0A;    // arbitrary value
	localparam logic [3:0]  REV   = 4'h9;     // arbitrary value
	// fixed ones: bits 14..11, 6, 3 and 0
	localparam psr_word_type FIXED = 32'h00007849;

	logic         hclk;                 // bus clock
	logic         hresetn;              // async reset, active low
	logic         hsel;                 // slave select
	psr_word_type haddr;                // byte address
	logic [1:0]   htrans;               // transfer type
	logic         hwrite;               // write strobe
	logic [2:0]   hsize;                // transfer size
	psr_word_type hwdata;               // write data
	psr_word_type hrdata;               // read data
	logic         hreadyout;            // slave ready, also bus ready
	logic         hresp;                // response
	logic         link_up;              // link level
	logic         autoneg_complete;     // negotiation level
	logic         jabber_detect;        // jabber level
	logic         far_end_fault_detect; // remote fault level
	logic         irq;                  // interrupt
	int           err_count;            // mismatches
	int           checks_done;          // comparisons

	// ********************************************************************
	// clock, device and management station
	// ********************************************************************
	initial hclk = 1'b0;
	always #50 hclk = ~hclk;

	psr_top #(
		.ID_HIGH (ID_HI),
		.OUI_LOW (OUI_L),
		.MODEL   (MDL),
		.REVISION(REV)
	) dut (
		.hclk                (hclk),
		.hresetn             (hresetn),
		.hsel                (hsel),
		.haddr               (haddr),
		.htrans              (htrans),
		.hwrite              (hwrite),
		.hsize               (hsize),
		.hwdata              (hwdata),
		.hready              (hreadyout),
		.hrdata              (hrdata),
		.hreadyout           (hreadyout),
		.hresp               (hresp),
		.link_up             (link_up),
		.autoneg_complete    (autoneg_complete),
		.jabber_detect       (jabber_detect),
		.far_end_fault_detect(far_end_fault_detect),
		.irq                 (irq)
	);

	psr_mgmt_station station (
		.hclk  (hclk),
		.hready(hreadyout),
		.hrdata(hrdata),
		.hsel  (hsel),
		.haddr (haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize (hsize),
		.hwdata(hwdata)
	);

	// ********************************************************************
	// compare, access and closing tasks
	// ********************************************************************
	task automatic check_word(input psr_word_type got, input psr_word_type exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check_bit(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// read a register and compare it with the expected word
	task automatic read_check(input psr_index_type idx, input psr_word_type exp);
		psr_word_type rd;
		station.bus_xfer(1'b0, idx, 32'h00000000, rd);
		check_word(rd, exp);
		check_bit(hresp, 1'b0);
	endtask

	task automatic write_reg(input psr_index_type idx, input psr_word_type wd);
		psr_word_type rd;
		station.bus_xfer(1'b1, idx, wd, rd);
	endtask

	// irq lags the register change by one edge; look at it when settled
	task automatic irq_check(input logic exp);
		@(posedge hclk);
		@(negedge hclk);
		check_bit(irq, exp);
	endtask

	task automatic finish_test;
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// ********************************************************************
	// watchdog: the whole sequence needs about a hundred cycles
	// ********************************************************************
	initial begin
		#(5000 * 100);
		err_count++;
		finish_test();
	end

	// ********************************************************************
	// test sequence
	// ********************************************************************
	initial begin
		err_count            = 0;
		checks_done          = 0;
		hresetn              = 1'b0;
		link_up              = 1'b0;
		autoneg_complete     = 1'b0;
		jabber_detect        = 1'b0;
		far_end_fault_detect = 1'b0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		// reset contents and read-only words
		read_check(`PSR_IDX_STATUS, FIXED);
		read_check(`PSR_IDX_ID_HIGH, {16'h0000, ID_HI});
		read_check(`PSR_IDX_ID_LOW, {16'h0000, OUI_L, MDL, REV});
		write_reg(`PSR_IDX_ID_HIGH, 32'hFFFFFFFF);
		write_reg(`PSR_IDX_STATUS, 32'hFFFFFFFF);
		read_check(`PSR_IDX_ID_HIGH, {16'h0000, ID_HI});
		read_check(`PSR_IDX_STATUS, FIXED);
		read_check(`PSR_IDX_INT_MASK, 32'h00000000);
		read_check(`PSR_IDX_INT_STAT, 32'h00000000);
		read_check(6'h20, 32'h00000000);
		// link and negotiation levels
		@(posedge hclk);
		link_up          <= 1'b1;
		autoneg_complete <= 1'b1;
		read_check(`PSR_IDX_STATUS, FIXED | 32'h24);
		@(posedge hclk);
		link_up <= 1'b0;
		read_check(`PSR_IDX_STATUS, FIXED | 32'h20);
		// one-cycle fault pulse stays latched until one read
		@(posedge hclk);
		far_end_fault_detect <= 1'b1;
		@(posedge hclk);
		far_end_fault_detect <= 1'b0;
		read_check(`PSR_IDX_STATUS, FIXED | 32'h30);
		read_check(`PSR_IDX_STATUS, FIXED | 32'h20);
		// jabber held through reads, then one read after it ends clears
		@(posedge hclk);
		jabber_detect <= 1'b1;
		read_check(`PSR_IDX_STATUS, FIXED | 32'h22);
		read_check(`PSR_IDX_STATUS, FIXED | 32'h22);
		@(posedge hclk);
		jabber_detect <= 1'b0;
		read_check(`PSR_IDX_STATUS, FIXED | 32'h22);
		read_check(`PSR_IDX_STATUS, FIXED | 32'h20);
		// every event source has landed; masked off, no interrupt
		read_check(`PSR_IDX_INT_STAT, 32'h0000000F);
		irq_check(1'b0);
		write_reg(`PSR_IDX_INT_MASK, 32'h00000001);
		irq_check(1'b1);
		read_check(`PSR_IDX_INT_MASK, 32'h00000001);
		write_reg(`PSR_IDX_INT_STAT, 32'h00000001);
		irq_check(1'b0);
		read_check(`PSR_IDX_INT_STAT, 32'h0000000E);
		write_reg(`PSR_IDX_INT_MASK, 32'h00000004);
		irq_check(1'b1);
		write_reg(`PSR_IDX_INT_STAT, 32'h0000000E);
		irq_check(1'b0);
		read_check(`PSR_IDX_INT_STAT, 32'h00000000);
		// a mid-run reset drops the latches, the mask and the events
		@(posedge hclk);
		jabber_detect <= 1'b1;
		@(posedge hclk);
		jabber_detect <= 1'b0;
		hresetn       <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		read_check(`PSR_IDX_STATUS, FIXED | 32'h20);
		read_check(`PSR_IDX_INT_MASK, 32'h00000000);
		// negotiation still high at release counts as a fresh rise
		read_check(`PSR_IDX_INT_STAT, 32'h00000008);
		irq_check(1'b0);
		finish_test();
	end
endmodule
